// File: verilog/uhrie_cfg.svh
`ifndef UHRIE_CFG_SVH
`define UHRIE_CFG_SVH
`define UHRIE_A_HOLD    8'h00
`define UHRIE_A_IEN     8'h04
`define UHRIE_A_FCTL    8'h08
`define UHRIE_A_IDENT   8'h0c
`define UHRIE_A_LSTAT   8'h10
`define UHRIE_A_MSTAT   8'h14
`define UHRIE_A_SRC     8'h18
`define UHRIE_IEN_RST   8'h00
`define UHRIE_FCTL_RST  8'h00
`define UHRIE_TRIG0     8'd8
`define UHRIE_TRIG1     8'd16
`define UHRIE_TRIG2     8'd24
`define UHRIE_TRIG3     8'd28
`define UHRIE_MID_CNT   4'd7
`define UHRIE_BIT_CNT   4'd15
`define UHRIE_ID_NONE   8'h01
`define UHRIE_ID_LINE   8'h06
`define UHRIE_ID_RX     8'h04
`define UHRIE_ID_TX     8'h02
`define UHRIE_ID_MODEM  8'h00
`define UHRIE_ID_XOFF   8'h10
`define UHRIE_ID_FLOW   8'h20
`define UHRIE_HTRANS_NS 2'b10
`endif

// File: verilog/uhrie_pkg.sv
package uhrie_pkg;
   typedef struct packed {
      logic [1:0] htrans;
      logic [7:0] haddr;
      logic       hwrite;
      logic [2:0] hsize;
      logic       hsel;
      logic       hready;
   } uhrie_ahb_req_t;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11,
      RX_STOP  = 2'b10
   } uhrie_rx_st_t;
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_START = 2'b01,
      TX_DATA  = 2'b11,
      TX_STOP  = 2'b10
   } uhrie_tx_st_t;
endpackage

// File: verilog/uhrie_top.sv
`timescale 1ns/10ps
`include "uhrie_cfg.svh"
module uhrie_top #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    srst,
   // AHB-Lite slave
   input  wire uhrie_pkg::uhrie_ahb_req_t ahb,
   input  wire logic [31:0]             hwdata,
   output logic [31:0]                  hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   // Serial line and sample clock tick
   input  wire logic                    tick16,
   input  wire logic                    sin,
   output logic                         sout,
   // Modem, line and flow status inputs
   input  wire logic                    cts,
   input  wire logic                    rts,
   input  wire logic [3:0]              modem_change,
   input  wire logic [3:0]              line_err,
   input  wire logic                    xoff_rcvd,
   // Outputs
   output logic                         irq,
   output logic                         sleep_en
);
   import uhrie_pkg::*;

   function automatic logic [7:0] trig_of(input logic [1:0] code);
      case (code)
         2'b00:   trig_of = `UHRIE_TRIG0;
         2'b01:   trig_of = `UHRIE_TRIG1;
         2'b10:   trig_of = `UHRIE_TRIG2;
         default: trig_of = `UHRIE_TRIG3;
      endcase
   endfunction

   // Bus phase registers
   logic       wr_q, wr_d, rd_q, rd_d;
   logic [7:0] a_q, a_d;
   logic [7:0] ien_q, ien_d, fctl_q, fctl_d;
   logic [7:0] rdat_q, rdat_d;
   // FIFOs
   logic [7:0]  txm_q [DEPTH], txm_d [DEPTH];
   logic [7:0]  rxm_q [DEPTH], rxm_d [DEPTH];
   logic [AW-1:0] twp_q, twp_d, trp_q, trp_d, rwp_q, rwp_d, rrp_q, rrp_d;
   logic [AW:0]   tcnt_q, tcnt_d, rcnt_q, rcnt_d;
   // Sticky sources
   logic cts_q, cts_d, rts_q, rts_d;
   logic cts_ev_q, cts_ev_d, rts_ev_q, rts_ev_d, xoff_q, xoff_d;
   logic txe_q, txe_d, thre_q, thre_d;
   // Serial state
   uhrie_rx_st_t rst_q, rst_d;
   uhrie_tx_st_t tst_q, tst_d;
   logic [3:0] rtk_q, rtk_d, ttk_q, ttk_d;
   logic [2:0] rbit_q, rbit_d, tbit_q, tbit_d;
   logic [7:0] rsh_q, rsh_d, tsh_q, tsh_d;
   logic       sin_q, sin_d, sout_q, sout_d;

   logic fifo_en, wr_hold, rd_hold, rd_ident, rx_push, tx_pop, rx_trig;
   logic tx_full, rx_full, rx_pend;
   logic [7:0] ident, lstat, srcs;

   assign fifo_en = fctl_q[0];
   assign tx_full = fifo_en ? (tcnt_q == (AW+1)'(DEPTH)) : (tcnt_q != '0);
   assign rx_full = fifo_en ? (rcnt_q == (AW+1)'(DEPTH)) : (rcnt_q != '0);
   assign rx_trig = fifo_en && ({{(7-AW){1'b0}}, rcnt_q} >= trig_of(fctl_q[7:6]));
   assign rx_pend = fifo_en ? rx_trig : (rcnt_q != '0);
   assign wr_hold = wr_q && a_q == `UHRIE_A_HOLD;
   assign rd_hold = rd_d && a_d == `UHRIE_A_HOLD && rcnt_q != '0;
   assign rd_ident = rd_d && a_d == `UHRIE_A_IDENT;
   assign tx_pop  = tst_q == TX_IDLE && tcnt_q != '0;
   assign rx_push = rst_q == RX_STOP && tick16 && rtk_q == `UHRIE_BIT_CNT
                    && !rx_full;

   // Pending sources, masked by enables without touching status
   assign srcs = {cts_ev_q, rts_ev_q, xoff_q, 1'b0, |modem_change,
                  |line_err, txe_q, rx_pend};
   assign irq  = |(srcs & ien_q & 8'hef);
   assign sleep_en = ien_q[4];
   assign lstat = {1'b0, tcnt_q == '0 && tst_q == TX_IDLE, thre_q,
                   line_err, rcnt_q != '0};
   always_comb begin
      if (ien_q[2] && |line_err)              ident = `UHRIE_ID_LINE;
      else if (ien_q[0] && rx_pend)           ident = `UHRIE_ID_RX;
      else if (ien_q[1] && txe_q)             ident = `UHRIE_ID_TX;
      else if (ien_q[3] && |modem_change)     ident = `UHRIE_ID_MODEM;
      else if (ien_q[5] && xoff_q)            ident = `UHRIE_ID_XOFF;
      else if (|(ien_q[7:6] & {cts_ev_q, rts_ev_q})) ident = `UHRIE_ID_FLOW;
      else                                    ident = `UHRIE_ID_NONE;
   end

   // Bus and register next state
   always_comb begin
      rd_d   = ahb.hsel && ahb.hready && ahb.htrans == `UHRIE_HTRANS_NS
               && !ahb.hwrite;
      wr_d   = ahb.hsel && ahb.hready && ahb.htrans == `UHRIE_HTRANS_NS
               && ahb.hwrite;
      a_d    = ahb.haddr;
      ien_d  = ien_q;
      fctl_d = fctl_q;
      rdat_d = rdat_q;
      if (wr_q && a_q == `UHRIE_A_IEN)  ien_d  = hwdata[7:0];
      if (wr_q && a_q == `UHRIE_A_FCTL) fctl_d = hwdata[7:0] & 8'hf9;
      if (rd_d) begin
         case (a_d)
            `UHRIE_A_HOLD:  rdat_d = rxm_q[rrp_q];
            `UHRIE_A_IEN:   rdat_d = ien_q;
            `UHRIE_A_FCTL:  rdat_d = fctl_q;
            `UHRIE_A_IDENT: rdat_d = ident;
            `UHRIE_A_LSTAT: rdat_d = lstat;
            `UHRIE_A_MSTAT: rdat_d = {4'h0, modem_change};
            `UHRIE_A_SRC:   rdat_d = srcs;
            default:        rdat_d = '0;
         endcase
      end
   end
   assign hrdata    = {24'h000000, rdat_q};
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // FIFO and flag next state
   always_comb begin
      txm_d  = txm_q;
      rxm_d  = rxm_q;
      twp_d  = twp_q;
      trp_d  = trp_q;
      rwp_d  = rwp_q;
      rrp_d  = rrp_q;
      tcnt_d = tcnt_q;
      rcnt_d = rcnt_q;
      if (wr_hold && !tx_full) begin
         txm_d[twp_q] = hwdata[7:0];
         twp_d = twp_q + 1'b1;
      end
      if (tx_pop) trp_d = trp_q + 1'b1;
      tcnt_d = tcnt_q + (AW+1)'(wr_hold && !tx_full) - (AW+1)'(tx_pop);
      if (rx_push) begin
         rxm_d[rwp_q] = rsh_q;
         rwp_d = rwp_q + 1'b1;
      end
      if (rd_hold) rrp_d = rrp_q + 1'b1;
      rcnt_d = rcnt_q + (AW+1)'(rx_push) - (AW+1)'(rd_hold);
      if (wr_q && a_q == `UHRIE_A_FCTL) begin
         if (hwdata[2] || hwdata[0] != fctl_q[0]) begin
            twp_d  = '0;
            trp_d  = '0;
            tcnt_d = '0;
         end
         if (hwdata[1] || hwdata[0] != fctl_q[0]) begin
            rwp_d  = '0;
            rrp_d  = '0;
            rcnt_d = '0;
         end
      end
      cts_d = cts;
      rts_d = rts;
      // Set wins over clear on every sticky flag
      cts_ev_d = (cts_ev_q && !rd_ident) || (cts && !cts_q);
      rts_ev_d = (rts_ev_q && !rd_ident) || (rts && !rts_q);
      xoff_d   = (xoff_q && !rd_ident) || xoff_rcvd;
      thre_d   = (tcnt_d == '0) || (thre_q && !wr_hold) || tx_pop;
      if (fifo_en)
         txe_d = (txe_q && !rd_ident && !wr_hold)
                 || (tx_pop && tcnt_q == (AW+1)'(1));
      else
         txe_d = tcnt_d == '0;
   end

   // Receiver and transmitter next state
   always_comb begin
      rst_d  = rst_q;
      rtk_d  = rtk_q;
      rbit_d = rbit_q;
      rsh_d  = rsh_q;
      tst_d  = tst_q;
      ttk_d  = ttk_q;
      tbit_d = tbit_q;
      tsh_d  = tsh_q;
      sin_d  = sin;
      sout_d = sout_q;
      // Receive framing
      case (rst_q)
         RX_IDLE: if (sin_q && !sin) begin
            rst_d = RX_START;
            rtk_d = '0;
         end
         RX_START: if (tick16) begin
            rtk_d = rtk_q + 1'b1;
            if (rtk_q == `UHRIE_MID_CNT) begin
               rtk_d  = '0;
               rbit_d = '0;
               rst_d = sin ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: if (tick16) begin
            rtk_d = rtk_q + 1'b1;
            if (rtk_q == `UHRIE_BIT_CNT) begin
               rsh_d = {sin, rsh_q[7:1]};
               rbit_d = rbit_q + 1'b1;
               if (rbit_q == 3'd7) rst_d = RX_STOP;
            end
         end
         RX_STOP: if (tick16) begin
            rtk_d = rtk_q + 1'b1;
            if (rtk_q == `UHRIE_BIT_CNT) rst_d = RX_IDLE;
         end
         default: rst_d = RX_IDLE;
      endcase
      // Transmit framing
      case (tst_q)
         TX_IDLE: begin
            sout_d = 1'b1;
            if (tx_pop) begin
               tsh_d = txm_q[trp_q];
               tst_d = TX_START;
               ttk_d = '0;
            end
         end
         TX_START: begin
            sout_d = 1'b0;
            if (tick16) begin
               ttk_d = ttk_q + 1'b1;
               if (ttk_q == `UHRIE_BIT_CNT) begin
                  tst_d  = TX_DATA;
                  tbit_d = '0;
                  sout_d = tsh_q[0];
               end
            end
         end
         TX_DATA: if (tick16) begin
            ttk_d = ttk_q + 1'b1;
            if (ttk_q == `UHRIE_BIT_CNT) begin
               tsh_d = {1'b1, tsh_q[7:1]};
               sout_d = tsh_q[1];
               tbit_d = tbit_q + 1'b1;
               if (tbit_q == 3'd7) begin
                  tst_d  = TX_STOP;
                  sout_d = 1'b1;
               end
            end
         end
         TX_STOP: if (tick16) begin
            ttk_d = ttk_q + 1'b1;
            if (ttk_q == `UHRIE_BIT_CNT) tst_d = TX_IDLE;
         end
         default: tst_d = TX_IDLE;
      endcase
   end
   assign sout = sout_q;

   // State registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         a_q      <= '0;
         rdat_q   <= '0;
         ien_q    <= `UHRIE_IEN_RST;
         fctl_q   <= `UHRIE_FCTL_RST;
         twp_q    <= '0;
         trp_q    <= '0;
         rwp_q    <= '0;
         rrp_q    <= '0;
         tcnt_q   <= '0;
         rcnt_q   <= '0;
         cts_q    <= 1'b0;
         rts_q    <= 1'b0;
         cts_ev_q <= 1'b0;
         rts_ev_q <= 1'b0;
         xoff_q   <= 1'b0;
         txe_q    <= 1'b0;
         thre_q   <= 1'b1;
         rst_q    <= RX_IDLE;
         tst_q    <= TX_IDLE;
         rtk_q    <= '0;
         ttk_q    <= '0;
         rbit_q   <= '0;
         tbit_q   <= '0;
         rsh_q    <= '0;
         tsh_q    <= '0;
         sin_q    <= 1'b1;
         sout_q   <= 1'b1;
      end else begin
         wr_q     <= wr_d;
         rd_q     <= rd_d;
         a_q      <= a_d;
         rdat_q   <= rdat_d;
         ien_q    <= ien_d;
         fctl_q   <= fctl_d;
         twp_q    <= twp_d;
         trp_q    <= trp_d;
         rwp_q    <= rwp_d;
         rrp_q    <= rrp_d;
         tcnt_q   <= tcnt_d;
         rcnt_q   <= rcnt_d;
         cts_q    <= cts_d;
         rts_q    <= rts_d;
         cts_ev_q <= cts_ev_d;
         rts_ev_q <= rts_ev_d;
         xoff_q   <= xoff_d;
         txe_q    <= txe_d;
         thre_q   <= thre_d;
         rst_q    <= rst_d;
         tst_q    <= tst_d;
         rtk_q    <= rtk_d;
         ttk_q    <= ttk_d;
         rbit_q   <= rbit_d;
         tbit_q   <= tbit_d;
         rsh_q    <= rsh_d;
         tsh_q    <= tsh_d;
         sin_q    <= sin_d;
         sout_q   <= sout_d;
      end
   end

   // FIFO storage
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_mem
         always_ff @(posedge mclk) begin
            txm_q[i] <= txm_d[i];
            rxm_q[i] <= rxm_d[i];
         end
      end
   endgenerate
endmodule

// File: verification/uhrie_line_peer.sv
`timescale 1ns/10ps
module uhrie_line_peer (
   // Clock
   input  wire logic mclk,
   // Sample tick and serial line
   output logic      tick16,
   output logic      sin
);
   logic t_q = 1'b0;
   initial sin = 1'b1;
   always @(posedge mclk) t_q <= ~t_q;
   assign tick16 = t_q;
   // Start, 8 data lsb first, stop; lo sets start length in cycles
   task automatic send(input logic [7:0] b, input int lo);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         sin <= f[i];
         repeat (i == 0 ? lo : 32) @(posedge mclk);
      end
   endtask
endmodule

// File: verification/uhrie_monitor.sv
`timescale 1ns/10ps
`include "uhrie_cfg.svh"
module uhrie_monitor #(
   parameter int DEPTH = 32,
   parameter int AW    = 5
) (
   // Clock, reset and bus
   input wire logic                      mclk,
   input wire logic                      srst,
   input wire uhrie_pkg::uhrie_ahb_req_t ahb,
   input wire logic [31:0]               hwdata,
   input wire logic [31:0]               hrdata,
   input wire logic                      hreadyout,
   input wire logic                      hresp,
   // Line and status
   input wire logic                      tick16,
   input wire logic                      sin,
   input wire logic                      sout,
   input wire logic                      cts,
   input wire logic                      rts,
   input wire logic [3:0]                modem_change,
   input wire logic [3:0]                line_err,
   input wire logic                      xoff_rcvd,
   input wire logic                      irq,
   input wire logic                      sleep_en
);
   import uhrie_pkg::*;
   logic       wr_q, wr_d;
   logic [7:0] ien_q, ien_d;
   always_comb begin
      wr_d = ahb.hsel && ahb.hready && ahb.htrans == `UHRIE_HTRANS_NS
             && ahb.hwrite && ahb.haddr == `UHRIE_A_IEN;
      ien_d = wr_q ? hwdata[7:0] : ien_q;
   end
   always_ff @(posedge mclk) begin
      wr_q  <= srst ? 1'b0 : wr_d;
      ien_q <= srst ? 8'h00 : ien_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_ien_wr;
      wr_q;
   endsequence
   a_reset_clear: assert property ($fell(srst) |-> !irq && !sleep_en)
      else $error("irq or sleep set after reset");
   a_sleep_bit: assert property (s_ien_wr |=> sleep_en == $past(hwdata[4]))
      else $error("sleep does not follow enable bit 4");
   a_irq_masked: assert property (ien_q == 8'h00 |-> !irq)
      else $error("irq with all enables clear");
   a_modem_irq: assert property ((ien_q[3] && |modem_change) [*3] |-> irq)
      else $error("modem change without irq");
   a_line_irq: assert property ((ien_q[2] && |line_err) [*3] |-> irq)
      else $error("line error without irq");
   a_cts_irq: assert property (ien_q[7] && $rose(cts) |-> ##[1:2] irq)
      else $error("cts rise without irq");
   a_rts_irq: assert property (ien_q[6] && $rose(rts) |-> ##[1:2] irq)
      else $error("rts rise without irq");
   a_xoff_irq: assert property (ien_q[5] && xoff_rcvd |-> ##[1:2] irq)
      else $error("xoff without irq");
endmodule
bind uhrie_top uhrie_monitor #(.DEPTH(DEPTH), .AW(AW)) u_mon (
   .mclk(mclk), .srst(srst), .ahb(ahb), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .tick16(tick16), .sin(sin),
   .sout(sout), .cts(cts), .rts(rts), .modem_change(modem_change),
   .line_err(line_err), .xoff_rcvd(xoff_rcvd), .irq(irq),
   .sleep_en(sleep_en));

// File: verification/tb_uart_holding_regs_irq_enable.sv
`timescale 1ns/10ps
`include "uhrie_cfg.svh"
module tb_uart_holding_regs_irq_enable;
   import uhrie_pkg::*;
   logic mclk = 1'b0, srst = 1'b1, tick16, sin, sout, irq, sleep_en;
   logic cts = 1'b0, rts = 1'b0, xoff_rcvd = 1'b0, hreadyout, hresp;
   logic [3:0] modem_change = 4'h0, line_err = 4'h0;
   logic [31:0] hwdata = 32'h0, hrdata, r;
   uhrie_ahb_req_t ahb = '{2'b00, 8'h00, 1'b0, 3'b010, 1'b1, 1'b1};
   int failures = 0, checked = 0;
   always @* ahb.hready = hreadyout;
   uhrie_top dut (.mclk(mclk), .srst(srst), .ahb(ahb), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .tick16(tick16), .sin(sin), .sout(sout), .cts(cts), .rts(rts),
      .modem_change(modem_change), .line_err(line_err),
      .xoff_rcvd(xoff_rcvd), .irq(irq), .sleep_en(sleep_en));
   uhrie_line_peer peer (.mclk(mclk), .tick16(tick16), .sin(sin));
   initial forever #25 mclk = ~mclk;
   task automatic chk(input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("FAIL t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      ahb.htrans <= `UHRIE_HTRANS_NS;
      ahb.haddr <= a;
      ahb.hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      ahb.htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_reset;
      bus(0, `UHRIE_A_IEN, 0);
      chk(r, `UHRIE_IEN_RST);
      chk(sleep_en, 0);
      chk(hresp, 0);
      chk(hreadyout, 1);
      bus(0, `UHRIE_A_LSTAT, 0);
      chk(r[5], 1);
      bus(1, `UHRIE_A_IEN, 32'h10);
      bus(0, `UHRIE_A_IEN, 0);
      chk(r, 32'h10);
      chk(sleep_en, 1);
      chk(irq, 0);
      bus(1, `UHRIE_A_IEN, 0);
      $display("reset test done");
   endtask
   task automatic t_rx;
      peer.send(8'hff, 8);
      bus(0, `UHRIE_A_LSTAT, 0);
      chk(r[0], 0);
      bus(1, `UHRIE_A_IEN, 32'h01);
      @(posedge mclk);
      chk(irq, 0);
      peer.send(8'ha5, 32);
      bus(0, `UHRIE_A_LSTAT, 0);
      chk(r[0], 1);
      chk(irq, 1);
      bus(0, `UHRIE_A_HOLD, 0);
      chk(r, 32'ha5);
      chk(irq, 0);
      bus(0, `UHRIE_A_LSTAT, 0);
      chk(r[0], 0);
      $display("receive test done");
   endtask
   task automatic t_tx;
      int n;
      bus(1, `UHRIE_A_IEN, 32'h02);
      bus(1, `UHRIE_A_HOLD, 32'h3c);
      n = 0;
      while (sout !== 1'b0 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      bus(0, `UHRIE_A_LSTAT, 0);
      chk(r[6:5], 2'b01);
      repeat (14) @(posedge mclk);
      chk(sout, 0);
      for (int i = 0; i < 8; i++) begin
         repeat (32) @(posedge mclk);
         chk(sout, (8'h3c >> i) & 8'h01);
      end
      repeat (48) @(posedge mclk);
      bus(0, `UHRIE_A_LSTAT, 0);
      chk(r[6:5], 2'b11);
      chk(irq, 1);
      $display("transmit test done");
   endtask
   task automatic t_fifo;
      bus(1, `UHRIE_A_IEN, 32'h01);
      bus(1, `UHRIE_A_FCTL, 32'h01);
      @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         chk(irq, 0);
         peer.send(8'h40 + i[7:0], 32);
      end
      chk(irq, 1);
      bus(0, `UHRIE_A_IDENT, 0);
      chk(r, `UHRIE_ID_RX);
      bus(0, `UHRIE_A_HOLD, 0);
      chk(r, 32'h40);
      chk(irq, 0);
      bus(1, `UHRIE_A_IEN, 32'h02);
      bus(1, `UHRIE_A_HOLD, 32'h55);
      repeat (2) @(posedge mclk);
      chk(irq, 1);
      bus(0, `UHRIE_A_IDENT, 0);
      chk(r, `UHRIE_ID_TX);
      chk(irq, 0);
      bus(1, `UHRIE_A_FCTL, 0);
      $display("fifo test done");
   endtask
   task automatic t_evt;
      bus(1, `UHRIE_A_IEN, 32'h20);
      xoff_rcvd <= 1'b1;
      @(posedge mclk);
      xoff_rcvd <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(irq, 1);
      bus(1, `UHRIE_A_IEN, 0);
      @(posedge mclk);
      chk(irq, 0);
      bus(0, `UHRIE_A_SRC, 0);
      chk(r[5], 1);
      bus(1, `UHRIE_A_IEN, 32'hcc);
      cts <= 1'b1;
      rts <= 1'b1;
      modem_change <= 4'h1;
      line_err <= 4'h2;
      repeat (4) @(posedge mclk);
      chk(irq, 1);
      modem_change <= 4'h0;
      line_err <= 4'h0;
      bus(1, `UHRIE_A_IEN, 0);
      $display("event test done");
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      t_reset;
      t_rx;
      t_tx;
      t_fifo;
      t_evt;
      final_report;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      final_report;
   end
endmodule
